// ---- design/lps_regs.sv ----
/*
 * Two-wire target, word-wide register map, threshold and persistence
 * interrupt logic of the light/proximity sensor.
 * Assumes scl/sda and results arrive from outside; measurement strobes and
 * results share the core clock. The open-drain sda and int pins are
 * resolved outside from the enables.
 */
// Overview of operation
// - Answer only at the fixed seven-bit address
// - Every access moves two bytes per command
// - Drive only acknowledges and read data
// - Flag register read clears pending interrupt
// - No light interrupt inside the window
// - Proximity interrupt above high or below low
// - Proximity events need persistence count of hits
// - Flags tell channel and threshold direction
// - Logic mode: assert high, release below low
// - Word zero low byte is light configuration
// - Word three holds proximity configuration bytes
// - Word four low byte: pulse, force, sunlight
// - Word four high byte: mode, white, current
// - Proximity thresholds at two consecutive codes
// - Light high threshold just below low threshold
// - Result words are read-only
// - White result word at its own code
// - Flag byte is high byte of word eleven
// - Proximity shutdown bit defaults to shut down
// - Light interrupt enable bit gates light events
module lps_regs
	import lps_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	// Two-wire bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Measurement results from the analog side
	input  wire logic        prox_done_in,
	input  wire logic [15:0] prox_result_in,
	input  wire logic        light_done_in,
	input  wire logic [15:0] light_result_in,
	input  wire logic        white_done_in,
	input  wire logic [15:0] white_result_in,
	// Configuration and interrupt pin
	output lps_cfg_s         cfg_out,
	output logic             int_out,
	output logic             int_oe_out
);

	// Bus states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RX   = 5'b00010,
		ST_ACK  = 5'b00100,
		ST_TX   = 5'b01000,
		ST_RACK = 5'b10000
	} lps_state_e;

	lps_state_e  state_reg;
	logic [2:0]  scl_sync_reg;   // Two sync stages plus edge history
	logic [2:0]  sda_sync_reg;
	logic [7:0]  shift_reg;      // Receive shifter
	logic [7:0]  tx_reg;         // Transmit shifter
	logic [7:0]  tx_hi_reg;      // High byte held for the second read byte
	logic [2:0]  bit_cnt_reg;
	logic [1:0]  byte_idx_reg;   // 0 address, 1 command, 2 low, 3 high
	logic        byte_done_reg;  // Byte taken and acknowledged pending
	logic        read_mode_reg;
	logic        hi_sent_reg;
	logic        rack_ok_reg;
	logic [7:0]  cmd_reg;
	logic [7:0]  wr_lo_reg;
	logic        sda_oe_reg;
	logic [15:0] rw_reg [LPS_RW_WORDS];
	logic [15:0] prox_res_reg;
	logic [15:0] light_res_reg;
	logic [15:0] white_res_reg;
	logic [7:0]  flags_reg;
	logic [3:0]  light_cnt_reg;  // Consecutive out-of-window light hits
	logic [2:0]  prox_cnt_reg;   // Consecutive proximity hits
	logic        close_reg;      // Logic mode object-near state
	logic        int_oe_reg;
	// Bus events, from the synchronised copies only
	wire scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
	wire scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
	wire sda_bit    = sda_sync_reg[1];
	wire start_cond = scl_sync_reg[1] & ~sda_sync_reg[1] & sda_sync_reg[2];
	wire stop_cond  = scl_sync_reg[1] & sda_sync_reg[1] & ~sda_sync_reg[2];
	wire [7:0] rx_byte  = {shift_reg[6:0], sda_bit};
	wire       last_bit = (bit_cnt_reg == 3'd7);
	wire       addr_hit = (rx_byte[7:1] == LPS_TARGET_ADDR);
	wire       wr_commit = scl_rise & (state_reg == ST_RX) & last_bit
		& (byte_idx_reg == 2'd3) & ~read_mode_reg;
	wire       rd_load = scl_rise & (state_reg == ST_RX) & last_bit
		& (byte_idx_reg == 2'd0) & addr_hit & rx_byte[0];
	// Configuration views
	wire [7:0] light_cfg  = rw_reg[CMD_LIGHT_CONF[2:0]][7:0];
	wire [7:0] prox_cfg_a = rw_reg[CMD_PROX_CONF_AB[2:0]][7:0];
	wire [7:0] prox_cfg_b = rw_reg[CMD_PROX_CONF_AB[2:0]][15:8];
	wire [7:0] prox_cfg_c = rw_reg[CMD_PROX_CONF_CM[2:0]][7:0];
	wire [7:0] prox_ms    = rw_reg[CMD_PROX_CONF_CM[2:0]][15:8];
	wire [15:0] light_hthr = rw_reg[CMD_LIGHT_HTHR[2:0]];
	wire [15:0] light_lthr = rw_reg[CMD_LIGHT_LTHR[2:0]];
	wire [15:0] prox_lthr  = rw_reg[CMD_PROX_LTHR[2:0]];
	wire [15:0] prox_hthr  = rw_reg[CMD_PROX_HTHR[2:0]];
	wire       light_sd   = light_cfg[LIGHT_SD_BIT];
	wire       light_ien  = light_cfg[LIGHT_IEN_BIT];
	wire       prox_sd    = prox_cfg_a[PROX_SD_BIT];
	wire [1:0] prox_trig  = prox_cfg_b[PROX_TRIG_LSB +: 2];
	wire       prox_logic = prox_ms[PROX_LOGIC_BIT];
	// Persistence targets: light 1/2/4/8, proximity 1..4
	wire [3:0] light_need = 4'h1 << light_cfg[LIGHT_PERS_LSB +: 2];
	wire [2:0] prox_need  = {1'b0, prox_cfg_a[PROX_PERS_LSB +: 2]} + 3'h1;
	// Result capture; 12-bit mode masks the upper nibble
	wire [15:0] prox_new = prox_cfg_b[PROX_RES16_BIT] ? prox_result_in
		: {4'h0, prox_result_in[11:0]};
	wire light_meas = light_done_in & ~light_sd;
	wire prox_meas  = prox_done_in & ~prox_sd;
	// Light window test: inside the window never counts
	wire light_above = light_result_in > light_hthr;
	wire light_below = light_result_in < light_lthr;
	wire light_out   = light_above | light_below;
	wire light_fire  = light_meas & light_ien & light_out
		& ((light_cnt_reg + 4'h1) >= light_need);
	// Proximity window test against the chosen trigger directions
	wire prox_above = prox_new > prox_hthr;
	wire prox_below = prox_new < prox_lthr;
	wire prox_hit   = (prox_above & (prox_trig[1] | prox_logic))
		| (prox_below & (prox_trig[0] | prox_logic));
	wire prox_fire  = prox_meas & prox_hit
		& ((prox_cnt_reg + 3'h1) >= prox_need);
	// Flag register read: captured with the word at address time
	wire flag_read = rd_load & (cmd_reg == CMD_EVENT_FLAGS);
	wire [7:0] flag_set = {2'b00,
		light_fire & light_below, light_fire & light_above, 2'b00,
		prox_fire & prox_above & ~prox_logic,
		prox_fire & prox_below & ~prox_logic};
	wire [7:0] flags_next = (flags_reg & {8{~flag_read}}) | flag_set;
	// Read word mux; undefined codes return zero
	logic [15:0] rd_word;
	always_comb begin
		rd_word = 16'h0000;
		if (cmd_reg < 8'(LPS_RW_WORDS)) begin
			rd_word = rw_reg[cmd_reg[2:0]];
		end else begin
			unique case (cmd_reg)
				CMD_PROX_RESULT:  rd_word = prox_res_reg;
				CMD_LIGHT_RESULT: rd_word = light_res_reg;
				CMD_WHITE_RESULT: rd_word = white_res_reg;
				CMD_EVENT_FLAGS:  rd_word = {flags_reg, 8'h00};
				CMD_PART_CODE:    rd_word = LPS_PART_CODE;
				default:          rd_word = 16'h0000;
			endcase
		end
	end
	// Pin synchronisers: stage 0 is read only by stage 1
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_reg <= 3'b111;
			sda_sync_reg <= 3'b111;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end
	// Target state machine; outputs change only after scl falls
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= 8'h00;
			tx_reg        <= 8'h00;
			tx_hi_reg     <= 8'h00;
			bit_cnt_reg   <= 3'd0;
			byte_idx_reg  <= 2'd0;
			byte_done_reg <= 1'b0;
			read_mode_reg <= 1'b0;
			hi_sent_reg   <= 1'b0;
			rack_ok_reg   <= 1'b0;
			cmd_reg       <= 8'h00;
			wr_lo_reg     <= 8'h00;
			sda_oe_reg    <= 1'b0;
		end else if (stop_cond) begin
			// Stop ends any transfer and frees the line
			state_reg  <= ST_IDLE;
			sda_oe_reg <= 1'b0;
		end else if (start_cond) begin
			// Start or repeated start begins an address byte
			state_reg     <= ST_RX;
			bit_cnt_reg   <= 3'd0;
			byte_idx_reg  <= 2'd0;
			byte_done_reg <= 1'b0;
			read_mode_reg <= 1'b0;
			sda_oe_reg    <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					sda_oe_reg <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						shift_reg   <= rx_byte;
						bit_cnt_reg <= bit_cnt_reg + 3'd1;
						if (last_bit) begin
							byte_done_reg <= 1'b1;
							if (byte_idx_reg == 2'd0) begin
								read_mode_reg <= rx_byte[0];
								// Foreign address: stay silent until next start
								if (!addr_hit) begin
									state_reg <= ST_IDLE;
								end
							end
							if (byte_idx_reg == 2'd1) begin
								cmd_reg <= rx_byte;
							end
							if (byte_idx_reg == 2'd2) begin
								wr_lo_reg <= rx_byte;
							end
							// Word read: low byte goes first, high held
							if (rd_load) begin
								tx_reg    <= rd_word[7:0];
								tx_hi_reg <= rd_word[15:8];
							end
						end
					end else if (scl_fall && byte_done_reg) begin
						// Acknowledge the byte just taken
						state_reg     <= ST_ACK;
						sda_oe_reg    <= 1'b1;
						byte_done_reg <= 1'b0;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt_reg <= 3'd0;
						if (read_mode_reg) begin
							// First data bit of the read word
							state_reg   <= ST_TX;
							sda_oe_reg  <= ~tx_reg[7];
							tx_reg      <= {tx_reg[6:0], 1'b0};
							hi_sent_reg <= 1'b0;
						end else begin
							state_reg    <= ST_RX;
							sda_oe_reg   <= 1'b0;
							// Extra bytes after the high byte each rewrite the word's high byte
							byte_idx_reg <= (byte_idx_reg == 2'd3) ? 2'd3
								: byte_idx_reg + 2'd1;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (last_bit) begin
							// Release for the host's acknowledge
							state_reg   <= ST_RACK;
							sda_oe_reg  <= 1'b0;
							rack_ok_reg <= 1'b0;
						end else begin
							sda_oe_reg  <= ~tx_reg[7];
							tx_reg      <= {tx_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 3'd1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						// Host ack after the low byte asks for the high byte
						if (!sda_bit && !hi_sent_reg) begin
							rack_ok_reg <= 1'b1;
							tx_reg      <= tx_hi_reg;
						end else begin
							state_reg <= ST_IDLE;
						end
					end else if (scl_fall && rack_ok_reg) begin
						state_reg   <= ST_TX;
						bit_cnt_reg <= 3'd0;
						sda_oe_reg  <= ~tx_reg[7];
						tx_reg      <= {tx_reg[6:0], 1'b0};
						hi_sent_reg <= 1'b1;
					end
				end
				default: begin
					state_reg  <= ST_IDLE;
					sda_oe_reg <= 1'b0;
				end
			endcase
		end
	end
	// Writable words; read-only codes ignore writes
	for (genvar w = 0; w < LPS_RW_WORDS; w++) begin : g_rw
		localparam logic [15:0] RST = (w == int'(CMD_LIGHT_CONF)) ? LIGHT_CONF_RST
			: (w == int'(CMD_PROX_CONF_AB)) ? PROX_CONF_RST : OTHER_RW_RST;
		always_ff @(posedge core_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				rw_reg[w] <= RST;
			end else if (wr_commit && cmd_reg == 8'(w)) begin
				rw_reg[w] <= {rx_byte, wr_lo_reg};
			end
		end
	end
	// Result words follow the measurements, never the bus
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prox_res_reg  <= 16'h0000;
			light_res_reg <= 16'h0000;
			white_res_reg <= 16'h0000;
		end else begin
			if (prox_meas) begin
				prox_res_reg <= prox_new;
			end
			if (light_meas) begin
				light_res_reg <= light_result_in;
			end
			if (white_done_in) begin
				white_res_reg <= white_result_in;
			end
		end
	end
	// Persistence counters reset on any in-window sample
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			light_cnt_reg <= 4'h0;
			prox_cnt_reg  <= 3'h0;
		end else begin
			if (light_meas) begin
				light_cnt_reg <= (!light_out || light_fire) ? 4'h0
					: light_cnt_reg + 4'h1;
			end
			if (prox_meas) begin
				prox_cnt_reg <= (!prox_hit || prox_fire) ? 3'h0
					: prox_cnt_reg + 3'h1;
			end
		end
	end
	// Flags and pin; a new event in the read cycle survives the clear
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_reg  <= 8'h00;
			close_reg  <= 1'b0;
			int_oe_reg <= 1'b0;
		end else begin
			flags_reg <= flags_next;
			if (!prox_logic) begin
				close_reg <= 1'b0;
			end else if (prox_fire && prox_above) begin
				close_reg <= 1'b1;
			end else if (prox_fire && prox_below) begin
				close_reg <= 1'b0;
			end
			// Logic mode pin follows the near state, not the flags
			int_oe_reg <= prox_logic ? close_reg : (flags_next != 8'h00);
		end
	end
	// Outputs straight from flip-flops; open-drain data is always low
	assign sda_out    = 1'b0;
	assign sda_oe_out = sda_oe_reg;
	assign int_out    = 1'b0;
	assign int_oe_out = int_oe_reg;
	assign cfg_out    = '{light_config_low:  light_cfg,
	                      prox_config_a:     prox_cfg_a,
	                      prox_config_b:     prox_cfg_b,
	                      prox_config_c:     prox_cfg_c,
	                      prox_mode_select:  prox_ms,
	                      prox_cancel_level: rw_reg[CMD_PROX_CANCEL[2:0]]};

endmodule : lps_regs

// ---- dv/lps_host_model.sv ----
/*
 * Behavioural two-wire bus controller in the host's place.
 * Assumes sda is resolved outside with a pull-up and fed back; scl rests high.
 */
module lps_host_model (
	// Pacing clock and resolved data line
	input  wire logic clk_in,
	input  wire logic sda_in,
	// Open-drain bus drive
	output logic      scl_out,
	output logic      sda_low_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Bus idle from time zero
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Pins move just after a core edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick
	// Start or repeated start; waits out the target's drive first
	task automatic start_c;
		sda_low_out = 1'b0;
		tick(4);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b1;
		tick(4);
		scl_out = 1'b0;
	endtask : start_c
	// Stop, then a long idle so the bus counts as free
	task automatic stop_c;
		sda_low_out = 1'b1;
		tick(4);
		scl_out = 1'b1;
		tick(4);
		sda_low_out = 1'b0;
		tick(16);
	endtask : stop_c
	// One bit: data in the low half, sampled mid high
	task automatic bit_c(input logic b, output logic r);
		tick(2);
		sda_low_out = !b;
		tick(2);
		scl_out = 1'b1;
		tick(2);
		r = sda_in;
		tick(2);
		scl_out = 1'b0;
	endtask : bit_c
	// Eight bits most significant first, then the acknowledge slot
	task automatic byte_c(input logic [7:0] b, input logic ack_b, output logic [7:0] r,
		output logic ack_r);
		for (int i = 7; i >= 0; i--) bit_c(b[i], r[i]);
		bit_c(ack_b, ack_r);
	endtask : byte_c
	// Word write; nbytes of 1 stops after the low byte
	task automatic wr_word(input logic [6:0] addr, input logic [7:0] cmd,
		input logic [15:0] data, input int nbytes, output logic [3:0] nacks);
		logic [7:0] junk;
		start_c();
		byte_c({addr, 1'b0}, 1'b1, junk, nacks[0]);
		byte_c(cmd, 1'b1, junk, nacks[1]);
		byte_c(data[7:0], 1'b1, junk, nacks[2]);
		nacks[3] = 1'b0;
		if (nbytes > 1)
			byte_c(data[15:8], 1'b1, junk, nacks[3]);
		stop_c();
	endtask : wr_word
	// Word read: ack the low byte, refuse the high byte
	task automatic rd_word(input logic [6:0] addr, input logic [7:0] cmd,
		output logic [15:0] data, output logic [2:0] nacks);
		logic [7:0] junk;
		logic       last;
		start_c();
		byte_c({addr, 1'b0}, 1'b1, junk, nacks[0]);
		byte_c(cmd, 1'b1, junk, nacks[1]);
		start_c();
		byte_c({addr, 1'b1}, 1'b1, junk, nacks[2]);
		byte_c(8'hFF, 1'b0, data[7:0], last);
		byte_c(8'hFF, 1'b1, data[15:8], last);
		stop_c();
	endtask : rd_word
endmodule : lps_host_model

// ---- dv/lps_regs_props.sv ----
/*
 * Checker for the light/proximity register block, bound to its top module.
 * Assumes one core clock domain and a host that rests scl high between frames.
 */
module lps_regs_props
	import lps_pkg::*;
(
	// Clock and reset
	input wire logic     core_clk_in,
	input wire logic     rst_n_in,
	// Bus pins
	input wire logic     scl_in,
	input wire logic     sda_out,
	input wire logic     sda_oe_out,
	// Measurement strobes
	input wire logic     prox_done_in,
	input wire logic     light_done_in,
	// Configuration and interrupt pin
	input wire lps_cfg_s cfg_out,
	input wire logic     int_out,
	input wire logic     int_oe_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] scl_hi_cnt; // Run of high scl samples, saturating
	logic       any_done;   // Either channel finished a sample
	logic       bus_idle;   // No frame in flight
	logic       cfg_rst_ok; // Shutdown-default bytes at their reset value
	assign any_done = prox_done_in | light_done_in;
	assign bus_idle = (scl_hi_cnt == 4'hF);
	assign cfg_rst_ok = (cfg_out.light_config_low == LIGHT_CONF_RST[7:0])
		&& (cfg_out.prox_config_a == PROX_CONF_RST[7:0]);
	// Saturated count means no frame is in flight
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_hi_cnt <= 4'hF;
		end else if (!scl_in) begin
			scl_hi_cnt <= 4'h0;
		end else if (scl_hi_cnt != 4'hF) begin
			scl_hi_cnt <= scl_hi_cnt + 4'h1;
		end
	end
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// A driven bit stays for at least half a bus clock, four core clocks
	sequence s_bit_held;
		sda_oe_out[*4];
	endsequence
	// Allows for a short result-to-pin pipeline
	sequence s_recent_done;
		$past(any_done, 1) || $past(any_done, 2) || $past(any_done, 3);
	endsequence
	AST_SDA_OD: assert property (sda_out == 1'b0)
		else $error("sda value not held low");
	AST_INT_OD: assert property (int_out == 1'b0)
		else $error("int value not held low");
	AST_OE_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in, 1))
		else $error("sda drive changed while scl high");
	AST_BIT_HOLD: assert property ($rose(sda_oe_out) |-> s_bit_held)
		else $error("driven bit too short");
	AST_IDLE_QUIET: assert property (scl_hi_cnt == 4'hF |-> !sda_oe_out)
		else $error("sda driven on idle bus");
	AST_RESET_CFG: assert property ($rose(rst_n_in) |-> cfg_rst_ok)
		else $error("configuration reset value wrong");
	AST_INT_CAUSE: assert property ($rose(int_oe_out) |-> s_recent_done)
		else $error("interrupt rose without a sample");
	AST_INT_IDLE: assert property ($changed(int_oe_out) && bus_idle |-> s_recent_done)
		else $error("interrupt moved on idle bus without a sample");
	AST_CFG_BY_BUS: assert property ($changed(cfg_out) |-> scl_hi_cnt < 4'h8)
		else $error("configuration changed without bus traffic");
endmodule : lps_regs_props

bind lps_regs lps_regs_props u_props (
	.core_clk_in   (core_clk_in),
	.rst_n_in      (rst_n_in),
	.scl_in        (scl_in),
	.sda_out       (sda_out),
	.sda_oe_out    (sda_oe_out),
	.prox_done_in  (prox_done_in),
	.light_done_in (light_done_in),
	.cfg_out       (cfg_out),
	.int_out       (int_out),
	.int_oe_out    (int_oe_out)
);

// ---- dv/lps_regs_tb.sv ----
/*
 * Self-checking bench for the light/proximity register block.
 * Assumes the host model for bus traffic and the bound checker.
 */
module lps_regs_tb
	import lps_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        core_clk, rst_n;            // Core clock and reset
	logic        prox_done, light_done, white_done;
	logic [15:0] prox_res, light_res, white_res;
	logic        scl, host_low, sda_oe, sda_od, int_oe, int_od;
	lps_cfg_s    cfg;                        // Configuration seen outside
	wire         sda_line = !(host_low || (sda_oe && !sda_od)); // Pull-up level
	int          fails, n_tests;
	logic [15:0] rd, exp;
	logic [3:0]  nk;
	logic [15:0] seq [6] = '{16'h0900, 16'h0900, 16'h0400, 16'h0900, 16'h0900, 16'h0900};
	lps_regs DUT (
		.core_clk_in     (core_clk),
		.rst_n_in        (rst_n),
		.scl_in          (scl),
		.sda_in          (sda_line),
		.sda_out         (sda_od),
		.sda_oe_out      (sda_oe),
		.prox_done_in    (prox_done),
		.prox_result_in  (prox_res),
		.light_done_in   (light_done),
		.light_result_in (light_res),
		.white_done_in   (white_done),
		.white_result_in (white_res),
		.cfg_out         (cfg),
		.int_out         (int_od),
		.int_oe_out      (int_oe)
	);
	lps_host_model host (
		.clk_in      (core_clk),
		.sda_in      (sda_line),
		.scl_out     (scl),
		.sda_low_out (host_low)
	);
	// Compare and count
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] seen);
		n_tests++;
		if (seen !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, seen);
		end
	endtask : check
	// Counts, verdict, end of run
	task automatic conclude;
		$display("Comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// Word write at our own address, all bytes acknowledged
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		host.wr_word(LPS_TARGET_ADDR, cmd, d, 2, nk);
		check("write acks", 16'h0000, {12'h000, nk});
	endtask : wr
	// Word read compared with an expected value
	task automatic rdchk(input string what, input logic [7:0] cmd, input logic [15:0] e);
		logic [2:0] n3;
		host.rd_word(LPS_TARGET_ADDR, cmd, rd, n3);
		check(what, e, rd);
		check("read acks", 16'h0000, {13'h0000, n3});
	endtask : rdchk
	// One finished sample on a channel: 0 prox, 1 light, 2 white
	task automatic meas(input int ch, input logic [15:0] v);
		@(posedge core_clk);
		#1;
		{prox_res, light_res, white_res} = {v, v, v};
		{prox_done, light_done, white_done} = {ch == 0, ch == 1, ch == 2};
		@(posedge core_clk);
		#1;
		{prox_done, light_done, white_done} = 3'b000;
		repeat (4) @(posedge core_clk);
		#1;
	endtask : meas
	// Interrupt pin pulled low when asserted
	task automatic intchk(input logic e);
		check("int pin", {15'h0000, e}, {15'h0000, int_oe});
	endtask : intchk
	// Free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		conclude();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{fails, n_tests} = '0;
		{prox_done, light_done, white_done} = 3'b000;
		{prox_res, light_res, white_res} = '0;
		repeat (8) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		check("light cfg", 16'h0001, {8'h00, cfg.light_config_low});
		check("prox cfg", 16'h0001, {8'h00, cfg.prox_config_a});
		// Reset map including one unmapped code
		for (int i = 0; i <= 13; i++) begin
			exp = (i == 0) ? LIGHT_CONF_RST : (i == 3) ? PROX_CONF_RST : OTHER_RW_RST;
			rdchk("reset word", i[7:0], (i == 12) ? LPS_PART_CODE : exp);
		end
		host.wr_word(7'h61, CMD_LIGHT_HTHR, 16'hFFFF, 2, nk);
		check("foreign nacks", 16'h000F, {12'h000, nk});
		// Writable words 1 to 7 hold a code-tagged pattern
		for (int i = 1; i <= 7; i++) begin
			wr(i[7:0], {i[3:0], 8'hA5, i[3:0]});
			rdchk("rw word", i[7:0], {i[3:0], 8'hA5, i[3:0]});
		end
		check("conf b", 16'h003A, {8'h00, cfg.prox_config_b});
		check("conf c", 16'h0054, {8'h00, cfg.prox_config_c});
		check("mode", 16'h004A, {8'h00, cfg.prox_mode_select});
		check("cancel", 16'h5A55, cfg.prox_cancel_level);
		host.wr_word(LPS_TARGET_ADDR, CMD_PROX_CANCEL, 16'h0000, 1, nk);
		rdchk("lone low byte", CMD_PROX_CANCEL, 16'h5A55);
		wr(CMD_PROX_RESULT, 16'hFFFF);
		rdchk("ro result", CMD_PROX_RESULT, 16'h0000);
		// Results with both channels on, no events
		wr(CMD_LIGHT_CONF, 16'h0000);
		wr(CMD_PROX_CONF_AB, 16'h0000);
		wr(CMD_PROX_CONF_CM, 16'h0000);
		meas(0, 16'hABCD);
		rdchk("prox 12 bit", CMD_PROX_RESULT, 16'h0BCD);
		wr(CMD_PROX_CONF_AB, 16'h0800);
		meas(0, 16'hABCD);
		rdchk("prox 16 bit", CMD_PROX_RESULT, 16'hABCD);
		meas(1, 16'h1234);
		intchk(1'b0);
		rdchk("light result", CMD_LIGHT_RESULT, 16'h1234);
		meas(2, 16'h5678);
		rdchk("white result", CMD_WHITE_RESULT, 16'h5678);
		// Light window with persistence of one
		wr(CMD_LIGHT_HTHR, 16'h1000);
		wr(CMD_LIGHT_LTHR, 16'h0100);
		wr(CMD_LIGHT_CONF, 16'h0002);
		meas(1, 16'h0800);
		intchk(1'b0);
		meas(1, 16'h1000);
		intchk(1'b0);
		meas(1, 16'h1001);
		intchk(1'b1);
		rdchk("light high flag", CMD_EVENT_FLAGS, 16'h1000);
		intchk(1'b0);
		rdchk("flags cleared", CMD_EVENT_FLAGS, 16'h0000);
		meas(1, 16'h00FF);
		intchk(1'b1);
		rdchk("light low flag", CMD_EVENT_FLAGS, 16'h2000);
		// Light persistence of two: a single hit must not fire
		wr(CMD_LIGHT_CONF, 16'h0006);
		meas(1, 16'h1001);
		intchk(1'b0);
		meas(1, 16'h1001);
		intchk(1'b1);
		rdchk("light pers flag", CMD_EVENT_FLAGS, 16'h1000);
		// Shut down light channel keeps its last result
		wr(CMD_LIGHT_CONF, 16'h0001);
		meas(1, 16'h4321);
		rdchk("light sd result", CMD_LIGHT_RESULT, 16'h1001);
		wr(CMD_LIGHT_CONF, 16'h0000);
		// Proximity, three hits needed, in-window sample restarts the count
		wr(CMD_PROX_LTHR, 16'h0100);
		wr(CMD_PROX_HTHR, 16'h0800);
		wr(CMD_PROX_CONF_AB, 16'h0B20);
		foreach (seq[k]) begin
			meas(0, seq[k]);
			intchk(k == 5);
		end
		rdchk("prox high flag", CMD_EVENT_FLAGS, 16'h0200);
		repeat (3) meas(0, 16'h0050);
		intchk(1'b1);
		rdchk("prox low flag", CMD_EVENT_FLAGS, 16'h0100);
		// Above-only trigger ignores a below-low sample
		wr(CMD_PROX_CONF_AB, 16'h0A00);
		meas(0, 16'h0050);
		intchk(1'b0);
		meas(0, 16'h0900);
		rdchk("above only flag", CMD_EVENT_FLAGS, 16'h0200);
		// Logic mode releases the pin by itself
		wr(CMD_PROX_CONF_AB, 16'h0B00);
		wr(CMD_PROX_CONF_CM, 16'h4000);
		meas(0, 16'h0900);
		intchk(1'b1);
		meas(0, 16'h0400);
		intchk(1'b1);
		meas(0, 16'h0050);
		intchk(1'b0);
		conclude();
	end
endmodule : lps_regs_tb

// ---- pkg/lps_pkg.sv ----
/*
 * Package for the light/proximity sensor register block: command codes,
 * reset values, field positions and the configuration carrier struct.
 * Assumes a single 100 MHz core clock domain in the design that imports it.
 */
package lps_pkg;

	// Fixed seven-bit target address
	localparam logic [6:0] LPS_TARGET_ADDR = 7'h60;

	// Command codes, one word each
	localparam logic [7:0] CMD_LIGHT_CONF   = 8'h00;
	localparam logic [7:0] CMD_LIGHT_HTHR   = 8'h01;
	localparam logic [7:0] CMD_LIGHT_LTHR   = 8'h02;
	localparam logic [7:0] CMD_PROX_CONF_AB = 8'h03;
	localparam logic [7:0] CMD_PROX_CONF_CM = 8'h04;
	localparam logic [7:0] CMD_PROX_CANCEL  = 8'h05;
	localparam logic [7:0] CMD_PROX_LTHR    = 8'h06;
	localparam logic [7:0] CMD_PROX_HTHR    = 8'h07;
	localparam logic [7:0] CMD_PROX_RESULT  = 8'h08;
	localparam logic [7:0] CMD_LIGHT_RESULT = 8'h09;
	localparam logic [7:0] CMD_WHITE_RESULT = 8'h0A;
	localparam logic [7:0] CMD_EVENT_FLAGS  = 8'h0B;
	localparam logic [7:0] CMD_PART_CODE    = 8'h0C;
	localparam int         LPS_RW_WORDS     = 8;

	// Reset values of the writable words
	localparam logic [15:0] LIGHT_CONF_RST = 16'h0001;
	localparam logic [15:0] PROX_CONF_RST  = 16'h0001;
	localparam logic [15:0] OTHER_RW_RST   = 16'h0000;

	// Part code, arbitrary neutral value
	localparam logic [15:0] LPS_PART_CODE = 16'h5A3C;

	// Field positions inside the configuration bytes
	localparam int LIGHT_SD_BIT     = 0;
	localparam int LIGHT_IEN_BIT    = 1;
	localparam int LIGHT_PERS_LSB   = 2;
	localparam int PROX_SD_BIT      = 0;
	localparam int PROX_PERS_LSB    = 4;
	localparam int PROX_TRIG_LSB    = 0;
	localparam int PROX_RES16_BIT   = 3;
	localparam int PROX_LOGIC_BIT   = 6;

	// Event flag bit positions
	localparam int FLAG_PROX_AWAY   = 0;
	localparam int FLAG_PROX_CLOSE  = 1;
	localparam int FLAG_LIGHT_HIGH  = 4;
	localparam int FLAG_LIGHT_LOW   = 5;

	// Configuration carried out to the analog side
	typedef struct packed {
		logic [7:0]  light_config_low;
		logic [7:0]  prox_config_a;
		logic [7:0]  prox_config_b;
		logic [7:0]  prox_config_c;
		logic [7:0]  prox_mode_select;
		logic [15:0] prox_cancel_level;
	} lps_cfg_s;

endpackage : lps_pkg
